// File: verilog/sfpa_consts.svh
// constants for the serial flash pin and array logic
//
// Contract
// - read data shifts out on falling clock edges
// - dual read drives both lanes, two bits per fall
// - output lane floats while chip select is high
// - low write-protect locks program and erase
// - floating write-protect reads as high, deasserted
// - pause suspends transfer, resumes at same point
// - paused: ignore clock and input, float output
// - self-timed erase and program ignore the pause
// - 4 KB and 32 KB aligned erase in 64 KB
// - program within one aligned 256-byte page
// - select falling starts, select rising ends operation
// - input bits sampled on rising clock edges
`ifndef SFPA_CONSTS_SVH
`define SFPA_CONSTS_SVH

// opcodes handled here
`define SFPA_OP_READ 8'h03
`define SFPA_OP_DREAD 8'h3B
`define SFPA_OP_PROG 8'h02
`define SFPA_OP_ERASE_4K 8'h20
`define SFPA_OP_ERASE_32K 8'h52
`define SFPA_OP_ERASE_CHIP 8'h60

// array geometry
`define SFPA_ADDR_W 16
`define SFPA_MEM_DEPTH 65536
`define SFPA_DATA_W 8
`define SFPA_MASK_4K 16'h0FFF
`define SFPA_MASK_32K 16'h7FFF
`define SFPA_MASK_CHIP 16'hFFFF
`define SFPA_ERASED 8'hFF

// serial framing counts
`define SFPA_CMD_LAST 5'h07
`define SFPA_ADDR_LAST 5'h17
`define SFPA_DUMMY_LAST 5'h07
`define SFPA_SINGLE_LAST 3'h7
`define SFPA_DUAL_LAST 3'h3

// write buffer shape
`define SFPA_FIFO_W 24
`define SFPA_FIFO_DEPTH 32

// pin synchroniser reset: {wp_n, hold_n, lane0, sck, cs_n}
`define SFPA_PIN_RST 5'h19

`endif

// File: verilog/sfpa_pkg.sv
// types shared by the serial flash pin and array logic
package sfpa_pkg;

    // serial protocol states, gray steps along cmd-addr-dummy-read
    typedef enum logic [2:0] {
        SFPA_CMD   = 3'b000,
        SFPA_ADDR  = 3'b001,
        SFPA_DUMMY = 3'b011,
        SFPA_READ  = 3'b010,
        SFPA_PROG  = 3'b110,
        SFPA_SKIP  = 3'b100
    } sfpa_state_e;

endpackage : sfpa_pkg

// File: verilog/sfpa_mem_if.sv
// array access bundle between protocol logic and storage
`timescale 1ns/1ps
`include "sfpa_consts.svh"

interface sfpa_mem_if;
    logic wr_en; // write strobe
    logic [`SFPA_ADDR_W-1:0] wr_addr; // write byte address
    logic [`SFPA_DATA_W-1:0] wr_data; // write byte
    logic rd_en; // read strobe
    logic [`SFPA_ADDR_W-1:0] rd_addr; // read byte address
    logic [`SFPA_DATA_W-1:0] rd_data; // registered read byte

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
                 input rd_en, input rd_addr, output rd_data);
endinterface : sfpa_mem_if

// File: verilog/sfpa_mem.sv
// byte array storage with registered read data
`timescale 1ns/1ps
`include "sfpa_consts.svh"

module sfpa_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    sfpa_mem_if.mem port_m
);
    // no reset on the array itself so it maps onto block ram
    logic [`SFPA_DATA_W-1:0] array_reg [0:`SFPA_MEM_DEPTH-1];

    // write port
    always_ff @(posedge clk) begin
        if (ce && port_m.wr_en) begin
            array_reg[port_m.wr_addr] <= port_m.wr_data;
        end
    end

    // read port, data held until the next strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_m.rd_data <= `SFPA_ERASED;
        end else if (ce && port_m.rd_en) begin
            port_m.rd_data <= array_reg[port_m.rd_addr];
        end
    end
endmodule : sfpa_mem

// File: verilog/sfpa_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps

module sfpa_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] slot_reg [0:DEPTH-1]; // storage
    logic [AW:0] wptr_reg; // write pointer with wrap bit
    logic [AW:0] rptr_reg; // read pointer with wrap bit

    // full when indices match and wrap bits differ
    wire full = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    wire empty = (wptr_reg == rptr_reg);
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = slot_reg[rptr_reg[AW-1:0]];

    // storage write
    always_ff @(posedge clk) begin
        if (ce && push) begin
            slot_reg[wptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else if (ce) begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
        end
    end
endmodule : sfpa_fifo

// File: verilog/sfpa_top.sv
// serial flash pin logic, command framing and array engine
`timescale 1ns/1ps
`include "sfpa_consts.svh"

module sfpa_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic dual_lane_zero_i,
    output logic dual_lane_zero_o,
    output logic dual_lane_zero_oe,
    output logic dual_lane_one_o,
    output logic dual_lane_one_oe,
    input wire logic wp_n,
    input wire logic hold_n,
    output logic busy
);
    // erase span mask per opcode
    function automatic logic [`SFPA_ADDR_W-1:0] erase_mask(input logic [7:0] op);
        if (op == `SFPA_OP_ERASE_4K) begin
            erase_mask = `SFPA_MASK_4K;
        end else if (op == `SFPA_OP_ERASE_32K) begin
            erase_mask = `SFPA_MASK_32K;
        end else begin
            erase_mask = `SFPA_MASK_CHIP;
        end
    endfunction : erase_mask

    // opcode writes the array
    function automatic logic is_write_op(input logic [7:0] op);
        is_write_op = (op == `SFPA_OP_PROG) || (op == `SFPA_OP_ERASE_4K)
            || (op == `SFPA_OP_ERASE_32K) || (op == `SFPA_OP_ERASE_CHIP);
    endfunction : is_write_op

    // pin synchroniser stages, first stage only feeds the second
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic sck_d_reg; // delayed clock for edge finding
    logic cs_d_reg; // delayed select for edge finding

    // protocol state
    sfpa_pkg::sfpa_state_e state_reg;
    logic [4:0] bit_cnt_reg; // input bits in the current field
    logic [23:0] shift_reg; // input shifter, address is 24 bits
    logic [7:0] op_reg; // latched opcode
    logic [`SFPA_ADDR_W-1:0] addr_reg; // running array address
    logic [7:0] out_reg; // output shifter
    logic [2:0] out_cnt_reg; // output steps within a byte
    logic drive_reg; // lanes driven after first falling edge
    logic dual_reg; // current read is two-lane
    logic held_reg; // pause condition active
    logic arm_reg; // erase waits for select to rise

    // output pin flops
    logic lane1_reg;
    logic lane0_reg;
    logic lane1_oe_reg;
    logic lane0_oe_reg;

    // erase engine
    logic er_busy_reg;
    logic [`SFPA_ADDR_W-1:0] er_addr_reg;
    logic [`SFPA_ADDR_W-1:0] er_end_reg;

    // array read request
    logic rd_en_reg;
    logic [`SFPA_ADDR_W-1:0] rd_addr_reg;

    // buffer between serial writes and the array
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`SFPA_FIFO_W-1:0] fifo_in_data;
    logic [`SFPA_FIFO_W-1:0] fifo_out_data;

    sfpa_mem_if mif ();

    // synchronised pin views
    wire cs_hi = pin_s2_reg[0];
    wire sck_s = pin_s2_reg[1];
    wire si_s = pin_s2_reg[2];
    wire hold_s_n = pin_s2_reg[3];
    wire wp_s_n = pin_s2_reg[4];

    // edges seen by the system clock
    wire sck_rise = sck_s && !sck_d_reg;
    wire sck_fall = !sck_s && sck_d_reg;
    wire cs_rise = cs_hi && !cs_d_reg;

    // a pause starts only while selected with the clock low
    wire hold_start = !cs_hi && !held_reg && !hold_s_n && !sck_s;
    wire held_next = cs_hi ? 1'b0 : (held_reg ? !hold_s_n : hold_start);

    // serial activity is gated by select and pause
    wire active = !cs_hi && !held_reg;
    wire rise_ok = active && sck_rise;
    wire fall_ok = active && sck_fall;

    // decoding of the bit just sampled
    wire [23:0] shift_in = {shift_reg[22:0], si_s};
    wire [7:0] op_in = shift_in[7:0];
    wire [`SFPA_ADDR_W-1:0] addr_in = shift_in[`SFPA_ADDR_W-1:0];
    wire locked = !wp_s_n;
    wire engine_idle = !er_busy_reg && !fifo_out_valid && !arm_reg;
    wire op_has_addr = (op_in == `SFPA_OP_READ) || (op_in == `SFPA_OP_DREAD)
        || (op_in == `SFPA_OP_PROG) || (op_in == `SFPA_OP_ERASE_4K)
        || (op_in == `SFPA_OP_ERASE_32K);
    wire op_refused = !engine_idle || (is_write_op(op_in) && locked);
    wire chip_arm = !op_refused && (op_in == `SFPA_OP_ERASE_CHIP);
    wire cmd_done = rise_ok && (state_reg == sfpa_pkg::SFPA_CMD)
        && (bit_cnt_reg == `SFPA_CMD_LAST);
    wire addr_done = rise_ok && (state_reg == sfpa_pkg::SFPA_ADDR)
        && (bit_cnt_reg == `SFPA_ADDR_LAST);
    wire dummy_done = rise_ok && (state_reg == sfpa_pkg::SFPA_DUMMY)
        && (bit_cnt_reg == `SFPA_DUMMY_LAST);
    wire prog_byte = rise_ok && (state_reg == sfpa_pkg::SFPA_PROG)
        && (bit_cnt_reg[2:0] == 3'h7);
    wire addr_is_erase = (op_reg == `SFPA_OP_ERASE_4K) || (op_reg == `SFPA_OP_ERASE_32K);

    // state after a complete opcode
    wire sfpa_pkg::sfpa_state_e cmd_next = (op_refused || !op_has_addr)
        ? sfpa_pkg::SFPA_SKIP : sfpa_pkg::SFPA_ADDR;

    // state after a complete address
    wire sfpa_pkg::sfpa_state_e addr_next =
        (op_reg == `SFPA_OP_READ) ? sfpa_pkg::SFPA_READ :
        (op_reg == `SFPA_OP_DREAD) ? sfpa_pkg::SFPA_DUMMY :
        (op_reg == `SFPA_OP_PROG) ? sfpa_pkg::SFPA_PROG : sfpa_pkg::SFPA_SKIP;

    // output step: reload from the array on a byte boundary
    wire out_load = (out_cnt_reg == 3'h0);
    wire [7:0] out_src = out_load ? mif.rd_data : out_reg;
    wire [2:0] out_last = dual_reg ? `SFPA_DUAL_LAST : `SFPA_SINGLE_LAST;
    wire read_fall = fall_ok && (state_reg == sfpa_pkg::SFPA_READ);

    // program bytes stay inside the page: low byte wraps, page bits hold
    wire [`SFPA_ADDR_W-1:0] prog_next = {addr_reg[`SFPA_ADDR_W-1:8],
        addr_reg[7:0] + 8'h01};
    wire [`SFPA_ADDR_W-1:0] erase_span = erase_mask(op_reg);

    // a byte arriving on a full buffer is dropped, never blocks the link
    assign fifo_in_valid = prog_byte;
    assign fifo_in_data = {addr_reg, shift_in[7:0]};
    assign fifo_out_ready = !er_busy_reg;

    // array write mux, erase has the port while it runs
    assign mif.wr_en = er_busy_reg || fifo_out_valid;
    assign mif.wr_addr = er_busy_reg ? er_addr_reg
        : fifo_out_data[`SFPA_FIFO_W-1:`SFPA_DATA_W];
    assign mif.wr_data = er_busy_reg ? `SFPA_ERASED : fifo_out_data[`SFPA_DATA_W-1:0];
    assign mif.rd_en = rd_en_reg;
    assign mif.rd_addr = rd_addr_reg;

    // outputs straight from flops
    assign dual_lane_one_o = lane1_reg;
    assign dual_lane_one_oe = lane1_oe_reg;
    assign dual_lane_zero_o = lane0_reg;
    assign dual_lane_zero_oe = lane0_oe_reg;
    assign busy = er_busy_reg;

    // pin synchronisers, reset to idle levels with write-protect high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_reg <= `SFPA_PIN_RST;
            pin_s2_reg <= `SFPA_PIN_RST;
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else if (ce) begin
            pin_s1_reg <= {wp_n, hold_n, dual_lane_zero_i, sck, cs_n};
            pin_s2_reg <= pin_s1_reg;
            sck_d_reg <= sck_s;
            cs_d_reg <= cs_hi;
        end
    end

    // pause tracking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            held_reg <= 1'b0;
        end else if (ce) begin
            held_reg <= held_next;
        end
    end

    // input side: framing, opcode, address, program data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= sfpa_pkg::SFPA_CMD;
            bit_cnt_reg <= 5'h00;
            shift_reg <= 24'h000000;
            op_reg <= 8'h00;
        end else if (ce) begin
            if (cs_hi) begin
                // deselected: next select starts a fresh opcode
                state_reg <= sfpa_pkg::SFPA_CMD;
                bit_cnt_reg <= 5'h00;
            end else if (rise_ok) begin
                shift_reg <= shift_in;
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if (cmd_done) begin
                    op_reg <= op_in;
                    state_reg <= cmd_next;
                    bit_cnt_reg <= 5'h00;
                end else if (addr_done) begin
                    state_reg <= addr_next;
                    bit_cnt_reg <= 5'h00;
                end else if (dummy_done) begin
                    state_reg <= sfpa_pkg::SFPA_READ;
                    bit_cnt_reg <= 5'h00;
                end else if (state_reg == sfpa_pkg::SFPA_SKIP) begin
                    // ignored until deselect, counter parked
                    bit_cnt_reg <= 5'h00;
                end
            end
        end
    end

    // address tracking and array read requests
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= '0;
            rd_en_reg <= 1'b0;
            rd_addr_reg <= '0;
        end else if (ce) begin
            rd_en_reg <= 1'b0;
            if (addr_done) begin
                // prefetch the first byte well before the first fall
                addr_reg <= addr_in;
                rd_en_reg <= 1'b1;
                rd_addr_reg <= addr_in;
            end else if (prog_byte) begin
                addr_reg <= prog_next;
            end else if (read_fall && out_load) begin
                // array data consumed, fetch the following byte
                addr_reg <= addr_reg + 16'h0001;
                rd_en_reg <= 1'b1;
                rd_addr_reg <= addr_reg + 16'h0001;
            end
        end
    end

    // output shifter, one or two bits per falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_reg <= 8'h00;
            out_cnt_reg <= 3'h0;
            lane1_reg <= 1'b0;
            lane0_reg <= 1'b0;
            drive_reg <= 1'b0;
            dual_reg <= 1'b0;
        end else if (ce) begin
            if (cs_hi) begin
                out_cnt_reg <= 3'h0;
                drive_reg <= 1'b0;
            end else if (addr_done) begin
                dual_reg <= (op_reg == `SFPA_OP_DREAD);
                out_cnt_reg <= 3'h0;
            end else if (read_fall) begin
                lane1_reg <= out_src[7];
                lane0_reg <= out_src[6];
                out_reg <= dual_reg ? {out_src[5:0], 2'b00} : {out_src[6:0], 1'b0};
                out_cnt_reg <= (out_cnt_reg == out_last) ? 3'h0 : out_cnt_reg + 3'h1;
                drive_reg <= 1'b1;
            end
        end
    end

    // output enables: off when deselected or paused
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lane1_oe_reg <= 1'b0;
            lane0_oe_reg <= 1'b0;
        end else if (ce) begin
            lane1_oe_reg <= !cs_hi && !held_next && drive_reg;
            lane0_oe_reg <= !cs_hi && !held_next && drive_reg && dual_reg;
        end
    end

    // erase arming and the self-timed engine, blind to the pause
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arm_reg <= 1'b0;
            er_busy_reg <= 1'b0;
            er_addr_reg <= '0;
            er_end_reg <= '0;
        end else if (ce) begin
            if (cmd_done && chip_arm) begin
                arm_reg <= 1'b1;
            end else if (addr_done && addr_is_erase) begin
                arm_reg <= 1'b1;
            end else if (cs_rise && arm_reg) begin
                // aligned span starts only once select rises
                arm_reg <= 1'b0;
                er_busy_reg <= 1'b1;
                er_addr_reg <= addr_reg & ~erase_span;
                er_end_reg <= addr_reg | erase_span;
            end else if (cs_hi && !cs_rise) begin
                arm_reg <= 1'b0;
            end
            if (er_busy_reg) begin
                er_addr_reg <= er_addr_reg + 16'h0001;
                if (er_addr_reg == er_end_reg) begin
                    er_busy_reg <= 1'b0;
                end
            end
        end
    end

    // program buffer, drained into the array when the engine is free
    sfpa_fifo #(
        .W(`SFPA_FIFO_W),
        .DEPTH(`SFPA_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // byte array
    sfpa_mem u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .port_m(mif.mem)
    );
endmodule : sfpa_top

// File: tb/sfpa_top_properties.sv
// assertion checker for the serial flash pin logic
`timescale 1ns/1ps
module sfpa_top_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic dual_lane_zero_o,
    input wire logic dual_lane_zero_oe,
    input wire logic dual_lane_one_o,
    input wire logic dual_lane_one_oe,
    input wire logic wp_n,
    input wire logic hold_n,
    input wire logic busy
);
    logic sck_d; // link clock one clk ago
    logic [3:0] fall_age; // clk since link clock fell, saturating
    logic [16:0] busy_len; // clk busy so far
    logic [9:0] wp_low; // clk with write protect low, saturating
    // helper counters; busy_len and wp_low cleared by reset, fall_age only by a link clock fall
    always_ff @(posedge clk) begin
        sck_d <= rst_n ? sck : 1'b0;
        fall_age <= (sck_d && !sck) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
        busy_len <= (busy && rst_n) ? busy_len + 17'h00001 : 17'h00000;
        wp_low <= (wp_n || !rst_n) ? 10'h000 : wp_low + {9'h000, wp_low != 10'h3FF};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_out_on_fall;
        $past(dual_lane_one_oe) && dual_lane_one_oe && $changed(dual_lane_one_o)
            |-> fall_age inside {[1:7]};
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("lane one moved off a fall");
    property p_dual_on_fall;
        $past(dual_lane_zero_oe) && dual_lane_zero_oe && $changed(dual_lane_zero_o)
            |-> fall_age inside {[1:7]};
    endproperty
    a_dual_on_fall: assert property (p_dual_on_fall)
        else $error("lane zero moved off a fall");
    property p_dual_pair;
        dual_lane_zero_oe |-> dual_lane_one_oe;
    endproperty
    a_dual_pair: assert property (p_dual_pair)
        else $error("lane zero without lane one");
    property p_float_desel;
        cs_n [*6] |-> !dual_lane_one_oe && !dual_lane_zero_oe;
    endproperty
    a_float_desel: assert property (p_float_desel)
        else $error("driven while deselected");
    property p_float_pause;
        (!hold_n && !cs_n) [*6] |-> !dual_lane_one_oe && !dual_lane_zero_oe;
    endproperty
    a_float_pause: assert property (p_float_pause)
        else $error("driven while paused");
    property p_wp_lock;
        $rose(busy) |-> wp_low < 10'h0C8;
    endproperty
    a_wp_lock: assert property (p_wp_lock)
        else $error("erase under write protect");
    // erase span length in clk
    property p_erase_len;
        $fell(busy) |-> busy_len inside {4096, 32768, 65536};
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase ran for a wrong span");
    property p_erase_in_pause;
        busy && !hold_n && busy_len < 17'h00FA0 |=> busy;
    endproperty
    a_erase_in_pause: assert property (p_erase_in_pause)
        else $error("erase stopped by a pause");
    property p_en_selected;
        $rose(dual_lane_one_oe) |-> !cs_n && hold_n && !busy;
    endproperty
    a_en_selected: assert property (p_en_selected)
        else $error("enable outside a frame");
    c_erase: cover property ($rose(busy));
    c_dual: cover property ($rose(dual_lane_zero_oe));
    c_pause: cover property (!hold_n && !cs_n && busy);
endmodule : sfpa_top_properties

bind sfpa_top sfpa_top_properties i_props (.*);

// File: tb/sfpa_host_model.sv
// host side link master model for the serial flash pin logic
`timescale 1ns/1ps
module sfpa_host_model (
    input wire logic clk,
    input wire logic lane0,
    input wire logic lane1,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic si_en,
    output logic hold_n
);
    localparam int HALF = 8; // clk per half link period, 80 ns period
    // idle: deselected, clock low as in mode 0
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        si_en = 1'b1;
        hold_n = 1'b1;
    end
    // every pin move lands on a falling clk edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic sel();
        tick(1);
        cs_n = 1'b0;
        tick(HALF);
    endtask : sel
    task automatic desel();
        tick(HALF);
        cs_n = 1'b1;
        tick(6);
    endtask : desel
    // one byte msb first; dual takes two bits per rise
    task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            si = tx[7 - i];
            tick(HALF);
            rx = dual ? {rx[5:0], lane1, lane0} : {rx[6:0], lane1};
            sck = 1'b1;
            tick(HALF);
            sck = 1'b0;
        end
    endtask : xfer
    // pause only when selected with clock low; wiggles must be ignored
    task automatic hold_on();
        hold_n = 1'b0;
        tick(HALF);
        repeat (2) begin
            sck = 1'b1;
            si = ~si;
            tick(HALF);
            sck = 1'b0;
            tick(HALF);
        end
    endtask : hold_on
    task automatic hold_off();
        hold_n = 1'b1;
        tick(HALF);
    endtask : hold_off
    // let go of lane zero while the device answers on it
    task automatic free_lane0(input logic f);
        si_en = ~f;
    endtask : free_lane0
endmodule : sfpa_host_model

// File: tb/tb.sv
// self-checking bench for the serial flash pin logic
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, ce, cs_n, sck, si_h, si_en, hold_n, wp_drv;
    logic z_o, z_oe, o_o, o_oe, busy;
    logic l0_last = 1'b0, l1_last = 1'b0; // last driven lane values
    wire lane0, lane1;
    tri1 wp_line; // pulled up like an unwired pin
    int err_count, checked;
    logic [7:0] ref_mem [int]; // expected array, absent means erased
    logic [15:0] pa;
    // released lanes show the inverse of the last value
    always @(posedge clk) begin
        if (z_oe) l0_last <= z_o;
        if (o_oe) l1_last <= o_o;
    end
    assign lane0 = z_oe ? z_o : (si_en ? si_h : ~l0_last);
    assign lane1 = o_oe ? o_o : ~l1_last;
    assign wp_line = wp_drv ? 1'b0 : 1'bz;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    sfpa_top i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .sck(sck),
        .dual_lane_zero_i(lane0), .dual_lane_zero_o(z_o), .dual_lane_zero_oe(z_oe),
        .dual_lane_one_o(o_o), .dual_lane_one_oe(o_oe), .wp_n(wp_line),
        .hold_n(hold_n), .busy(busy));
    sfpa_host_model i_host (.clk(clk), .lane0(lane0), .lane1(lane1), .cs_n(cs_n),
        .sck(sck), .si(si_h), .si_en(si_en), .hold_n(hold_n));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 8'hFF;
    endfunction : exp_rd
    // opcode and three address bytes, top byte ignored
    task automatic cmd(input logic [7:0] op, input logic [15:0] a);
        logic [7:0] r;
        i_host.sel();
        i_host.xfer(op, 1'b0, r);
        i_host.xfer(8'($urandom), 1'b0, r);
        i_host.xfer(a[15:8], 1'b0, r);
        i_host.xfer(a[7:0], 1'b0, r);
    endtask : cmd
    // read n bytes, optionally pausing before byte hold_at
    task automatic rd(input logic [15:0] a, input int n, input logic dual, input int hold_at);
        logic [7:0] r;
        cmd(dual ? 8'h3B : 8'h03, a);
        if (dual) i_host.xfer(8'($urandom), 1'b0, r);
        i_host.free_lane0(dual);
        for (int i = 0; i < n; i++) begin
            if (i == hold_at) begin
                i_host.hold_on();
                chk("paused enable", {6'h00, z_oe, o_oe}, 8'h00);
                i_host.hold_off();
            end
            i_host.xfer(8'($urandom), dual, r);
            chk("read byte", r, exp_rd(16'(a + i)));
        end
        i_host.free_lane0(1'b0);
        i_host.desel();
        chk("deselected enable", {6'h00, z_oe, o_oe}, 8'h00);
    endtask : rd
    // program n random bytes; the address wraps inside the page
    task automatic prog(input logic [15:0] a, input int n);
        logic [7:0] r, d;
        cmd(8'h02, a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            i_host.xfer(d, 1'b0, r);
            if (wp_drv !== 1'b1) ref_mem[int'({a[15:8], 8'(a[7:0] + i)})] = d;
        end
        i_host.desel();
    endtask : prog
    // erase the aligned span under mask m, pausing if pz
    task automatic erase(input logic [7:0] op, input logic [15:0] a, input logic [15:0] m,
                         input logic pz);
        int w;
        cmd(op, a);
        i_host.desel();
        chk("busy", {7'h00, busy}, {7'h00, ~wp_drv});
        if (wp_drv === 1'b1) return;
        foreach (ref_mem[k]) if ((k & ~int'(m)) == (int'(a) & ~int'(m))) ref_mem[k] = 8'hFF;
        if (pz) begin
            i_host.sel();
            i_host.hold_on();
            chk("busy in pause", {7'h00, busy}, 8'h01);
            i_host.hold_off();
            i_host.desel();
        end
        for (w = 0; busy === 1'b1 && w < 40000; w++) @(negedge clk);
        chk("busy end", {7'h00, busy}, 8'h00);
    endtask : erase
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // watchdog, well past the run length
    initial begin
        #400000;
        err_count++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        wp_drv = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        void'($urandom(16984));
        chk("reset outputs", {5'h00, busy, z_oe, o_oe}, 8'h00);
        // 32 KB erase wipes an earlier byte, with a pause during it
        prog(16'h9000, 1);
        erase(8'h52, 16'h8000 | 16'($urandom_range(0, 32767)), 16'h7FFF, 1'b1);
        rd(16'h9000, 1, 1'b0, -1);
        $display("test erase_32k done");
        // 4 KB erase, page wrap, read across a page with a pause
        erase(8'h20, 16'h3000 | 16'($urandom_range(0, 4095)), 16'h0FFF, 1'b0);
        prog(16'h35FE, 4);
        rd(16'h35FE, 4, 1'b0, 2);
        rd(16'h3500, 2, 1'b1, 1);
        $display("test page_wrap done");
        // write protect low refuses program and erase
        wp_drv = 1'b1;
        prog(16'h3500, 2);
        erase(8'h20, 16'h3000, 16'h0FFF, 1'b0);
        erase(8'h60, 16'h3000, 16'hFFFF, 1'b0);
        wp_drv = 1'b0;
        rd(16'h3500, 2, 1'b0, -1);
        // deselect in mid address starts nothing
        i_host.sel();
        i_host.xfer(8'h20, 1'b0, pa[7:0]);
        i_host.xfer(8'h00, 1'b0, pa[7:0]);
        i_host.desel();
        chk("busy", {7'h00, busy}, 8'h00);
        $display("test protect done");
        // random program and read back in the erased upper half
        for (int t = 0; t < 6; t++) begin
            pa = 16'h8000 | 16'($urandom_range(0, 32764));
            prog(pa, $urandom_range(1, 3));
            rd(pa, 3, 1'(t), -1);
        end
        $display("test random done");
        end_of_test();
    end
endmodule : tb
